// File: mdiof_defs.svh
// Constants of the motor driver discrete I/O function block
`ifndef MDIOF_DEFS_SVH
`define MDIOF_DEFS_SVH

// Clock and timing figures
`define MDIOF_CLK_NS 10
`define MDIOF_FILT_NS 10000000
`define MDIOF_PULSE_NS 200000
`define MDIOF_STEPS_PER_PULSE 4

// Terminal counts and field widths
`define MDIOF_N_IN 6
`define MDIOF_N_OUT 4
`define MDIOF_IN_CODE_W 4
`define MDIOF_OUT_CODE_W 5
`define MDIOF_N_IN_FUNC 16
`define MDIOF_N_OUT_FUNC 32
`define MDIOF_N_CAUSE 16
`define MDIOF_SPEED_W 16
`define MDIOF_DATA_W 3

// Input functions that read ON when not assigned to any terminal
`define MDIOF_IN_DEFAULT_ON 16'h6800

// Factory mapping, terminal 0 in the low field
`define MDIOF_IN_MAP_DEFAULT {IF_FAULT_CLR, IF_DS1, IF_DS0, IF_DIR_SEL, \
    IF_CMD_A, IF_RUN_DECEL}
`define MDIOF_OUT_MAP_DEFAULT {OF_DIRECTION, OF_TORQUE_CAPPED, \
    OF_FAULT_NC, OF_SPEED_PULSE}

// Reset values
`define MDIOF_DIR_FLAG_RESET 1'b1
`define MDIOF_MODE_THREE_WIRE 1'b0

`endif

// File: mdiof_filter.sv
// Input terminal synchroniser and debounce filter
`timescale 1ns/10ps
`include "mdiof_defs.svh"

module mdiof_filter #(
    parameter int unsigned STABLE_CYCLES = 1000000
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic raw,
    output logic level
);
    localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

    logic sync_a_r;
    logic sync_b_r;
    logic level_r;
    logic level_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // Level flips only after the synced input differs for the full time
    always_comb begin
        level_nxt = level_r;
        cnt_nxt = cnt_r;
        if (sync_b_r == level_r) begin
            cnt_nxt = '0;
        end else if (cnt_r == CW'(STABLE_CYCLES - 1)) begin
            level_nxt = sync_b_r;
            cnt_nxt = '0;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync_a_r <= 1'b0;
            sync_b_r <= 1'b0;
            level_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            sync_a_r <= raw;
            sync_b_r <= sync_a_r;
            level_r <= level_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign level = level_r;

endmodule : mdiof_filter

// File: mdiof_pkg.sv
// Types shared by the motor driver discrete I/O function block
package mdiof_pkg;

    // Input function codes held in each input terminal's map field
    typedef enum logic [3:0] {
        IF_NONE = 4'h0,
        IF_RUN_DECEL = 4'h1,
        IF_CMD_A = 4'h2,
        IF_DIR_SEL = 4'h3,
        IF_DS0 = 4'h4,
        IF_DS1 = 4'h5,
        IF_DS2 = 4'h6,
        IF_FAULT_CLR = 4'h7,
        IF_FWD = 4'h8,
        IF_REV = 4'h9,
        IF_STOP_STYLE = 4'hA,
        IF_TORQUE_CAP = 4'hB,
        IF_NOTICE_CLR = 4'hC,
        IF_TOOL_UNLOCK = 4'hD,
        IF_EXT_TRIP = 4'hE,
        IF_HOLD_REL = 4'hF
    } mdiof_in_func_type;

    // Output function codes; cause flags follow from OF_CAUSE0 upward
    typedef enum logic [4:0] {
        OF_NONE = 5'h00,
        OF_SPEED_PULSE = 5'h01,
        OF_FAULT_NC = 5'h02,
        OF_TORQUE_CAPPED = 5'h03,
        OF_DIRECTION = 5'h04,
        OF_FAULT_NO = 5'h05,
        OF_ROTATING = 5'h06,
        OF_NOTICE = 5'h07,
        OF_SPEED_REACHED = 5'h08,
        OF_CAUSE0 = 5'h09
    } mdiof_out_func_type;

    // Drive command to the commutation logic, Gray along stop-run-stop
    typedef enum logic [1:0] {
        DRV_DECEL_STOP = 2'h0,
        DRV_RUN = 2'h1,
        DRV_INSTANT_STOP = 2'h3,
        DRV_COAST = 2'h2
    } mdiof_drive_type;

endpackage : mdiof_pkg

// File: mdiof_plc.sv
// Controller model that drives the input terminals of the block
`timescale 1ns/10ps
module mdiof_plc (
    input wire logic clock,
    input wire logic [5:0] want,
    output logic [5:0] din
);
    // Levels move only on the falling edge, then hold until told otherwise
    always @(negedge clock) begin
        din <= want;
    end
endmodule : mdiof_plc

// File: mdiof_top.sv
// Discrete I/O function logic of a brushless motor driver
`timescale 1ns/10ps
`include "mdiof_defs.svh"

module mdiof_top #(
    parameter int unsigned FILT_CYCLES = `MDIOF_FILT_NS / `MDIOF_CLK_NS,
    parameter int unsigned PULSE_CYCLES = `MDIOF_PULSE_NS / `MDIOF_CLK_NS,
    parameter int unsigned STEPS_PER_PULSE = `MDIOF_STEPS_PER_PULSE
) (
    input wire logic clock,
    input wire logic nrst,
    // Terminals
    input wire logic [`MDIOF_N_IN-1:0] din,
    output logic [`MDIOF_N_OUT-1:0] dout,
    // Configuration
    input wire logic two_wire_mode,
    input wire logic map_load,
    input wire logic [`MDIOF_N_IN*`MDIOF_IN_CODE_W-1:0] in_map_cfg,
    input wire logic [`MDIOF_N_OUT*`MDIOF_OUT_CODE_W-1:0] out_map_cfg,
    input wire logic notice_auto_clear,
    input wire logic hold_enable,
    input wire logic [`MDIOF_SPEED_W-1:0] speed_width,
    // Driver status
    input wire logic motor_step,
    input wire logic motor_turning,
    input wire logic motor_reverse,
    input wire logic torque_limited,
    input wire logic [`MDIOF_SPEED_W-1:0] speed_detected,
    input wire logic [`MDIOF_SPEED_W-1:0] speed_command,
    input wire logic alarm_raise,
    input wire logic alarm_locked,
    input wire logic [`MDIOF_N_CAUSE-1:0] notice_cause_set,
    input wire logic [`MDIOF_N_CAUSE-1:0] notice_cause_present,
    // Commands to the driver
    output mdiof_pkg::mdiof_drive_type drive_cmd,
    output logic drive_forward,
    output logic [`MDIOF_DATA_W-1:0] data_number,
    output logic torque_cap_active,
    output logic tool_unlocked,
    output logic shaft_free,
    output logic alarm_active,
    output logic notice_flag
);
    import mdiof_pkg::*;

    localparam int unsigned NI = `MDIOF_N_IN;
    localparam int unsigned NO = `MDIOF_N_OUT;
    localparam int unsigned IW = `MDIOF_IN_CODE_W;
    localparam int unsigned OW = `MDIOF_OUT_CODE_W;
    localparam int unsigned NF = `MDIOF_N_IN_FUNC;
    localparam int unsigned NC = `MDIOF_N_CAUSE;
    localparam int unsigned SW = $clog2(STEPS_PER_PULSE + 1);
    localparam int unsigned PW = $clog2(PULSE_CYCLES + 1);

    logic [NI-1:0] filt;
    logic [NF-1:0] fl;
    logic [NF-1:0] dflt_on;

    genvar gt;
    generate
        for (gt = 0; gt < NI; gt++) begin : g_in
            mdiof_filter #(
                .STABLE_CYCLES(FILT_CYCLES)
            ) u_filt (
                .clock(clock),
                .nrst(nrst),
                .raw(din[gt]),
                .level(filt[gt])
            );
        end
    endgenerate

    // Terminal maps
    logic [NI*IW-1:0] in_map_r;
    logic [NI*IW-1:0] in_map_nxt;
    logic [NO*OW-1:0] out_map_r;
    logic [NO*OW-1:0] out_map_nxt;

    always_comb begin
        in_map_nxt = map_load ? in_map_cfg : in_map_r;
        out_map_nxt = map_load ? out_map_cfg : out_map_r;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            in_map_r <= `MDIOF_IN_MAP_DEFAULT;
            out_map_r <= `MDIOF_OUT_MAP_DEFAULT;
        end else begin
            in_map_r <= in_map_nxt;
            out_map_r <= out_map_nxt;
        end
    end

    // Function levels; one function on several terminals needs all ON
    assign dflt_on = `MDIOF_IN_DEFAULT_ON;
    always_comb begin
        logic asg;
        logic all_on;
        asg = 1'b0;
        all_on = 1'b1;
        fl = '0;
        for (int f = 0; f < NF; f++) begin
            asg = 1'b0;
            all_on = 1'b1;
            for (int t = 0; t < NI; t++) begin
                if (in_map_r[t*IW +: IW] == IW'(f)) begin
                    asg = 1'b1;
                    all_on = all_on & filt[t];
                end
            end
            fl[f] = asg ? all_on : dflt_on[f];
        end
    end

    // Named function levels
    logic run_decel;
    logic cmd_a;
    logic direction_select;
    logic data_select_bit0;
    logic data_select_bit1;
    logic data_select_bit2;
    logic fault_clear;
    logic forward_run;
    logic reverse_run;
    logic stop_style;
    logic torque_cap_enable;
    logic notice_clear;
    logic tool_unlock;
    logic external_trip;
    logic hold_release;
    assign run_decel = fl[IF_RUN_DECEL];
    assign cmd_a = fl[IF_CMD_A];
    assign direction_select = fl[IF_DIR_SEL];
    assign data_select_bit0 = fl[IF_DS0];
    assign data_select_bit1 = fl[IF_DS1];
    assign data_select_bit2 = fl[IF_DS2];
    assign fault_clear = fl[IF_FAULT_CLR];
    assign forward_run = fl[IF_FWD];
    assign reverse_run = fl[IF_REV];
    assign stop_style = fl[IF_STOP_STYLE];
    assign torque_cap_enable = fl[IF_TORQUE_CAP];
    assign notice_clear = fl[IF_NOTICE_CLR];
    assign tool_unlock = fl[IF_TOOL_UNLOCK];
    // Trip is active when the terminal goes OFF
    assign external_trip = ~fl[IF_EXT_TRIP];
    assign hold_release = fl[IF_HOLD_REL];

    // Control and status state
    mdiof_drive_type drive_r;
    mdiof_drive_type drive_nxt;
    logic fwd_r;
    logic fwd_nxt;
    logic [`MDIOF_DATA_W-1:0] data_r;
    logic [`MDIOF_DATA_W-1:0] data_nxt;
    logic tcap_r;
    logic tcap_nxt;
    logic unlock_r;
    logic unlock_nxt;
    logic free_r;
    logic free_nxt;
    logic alarm_r;
    logic alarm_nxt;
    logic [NC-1:0] cause_r;
    logic [NC-1:0] cause_nxt;
    logic fclr_prev_r;
    logic nclr_prev_r;
    logic dir_flag_r;
    logic dir_flag_nxt;
    logic reached_r;
    logic reached_nxt;
    logic run_req;
    logic [`MDIOF_SPEED_W-1:0] speed_diff;

    // Run is requested while either two-wire run input, or both three-wire start inputs, are ON
    assign run_req = two_wire_mode ? (forward_run | reverse_run)
                                   : (run_decel & cmd_a);
    assign speed_diff = (speed_detected >= speed_command) ?
        speed_detected - speed_command : speed_command - speed_detected;

    always_comb begin
        drive_nxt = DRV_DECEL_STOP;
        fwd_nxt = fwd_r;
        if (alarm_r | external_trip) begin
            // trip stops instantly, other alarms coast
            drive_nxt = external_trip ? DRV_INSTANT_STOP : DRV_COAST;
        end else if (!two_wire_mode) begin
            fwd_nxt = direction_select;
            if (!cmd_a) begin
                drive_nxt = DRV_INSTANT_STOP;
            end else if (run_decel) begin
                drive_nxt = DRV_RUN;
            end else begin
                drive_nxt = DRV_DECEL_STOP;
            end
        end else if (forward_run & reverse_run) begin
            drive_nxt = DRV_DECEL_STOP;
        end else if (forward_run | reverse_run) begin
            drive_nxt = DRV_RUN;
            fwd_nxt = forward_run;
        end else begin
            drive_nxt = stop_style ? DRV_INSTANT_STOP : DRV_DECEL_STOP;
        end
        data_nxt = {data_select_bit2, data_select_bit1, data_select_bit0};
        tcap_nxt = torque_cap_enable;
        unlock_nxt = tool_unlock;
        // free only a held, stopped shaft
        free_nxt = hold_enable & ~motor_turning & hold_release;
        // edge clear, blocked while running; raise wins
        alarm_nxt = alarm_r;
        if (fault_clear & ~fclr_prev_r & ~run_req & ~alarm_locked) begin
            alarm_nxt = 1'b0;
        end
        if (alarm_raise | external_trip) begin
            alarm_nxt = 1'b1;
        end
        // edge clear or auto clear; a new cause wins
        cause_nxt = cause_r;
        if (notice_clear & ~nclr_prev_r) begin
            cause_nxt = '0;
        end else if (notice_auto_clear) begin
            cause_nxt = cause_r & notice_cause_present;
        end
        cause_nxt = cause_nxt | notice_cause_set;
        dir_flag_nxt = dir_flag_r;
        if (motor_turning) begin
            dir_flag_nxt = ~motor_reverse;
        end
        // within plus or minus detection width
        reached_nxt = motor_turning & (speed_diff <= speed_width);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            drive_r <= DRV_DECEL_STOP;
            fwd_r <= 1'b1;
            data_r <= '0;
            tcap_r <= 1'b0;
            unlock_r <= 1'b0;
            free_r <= 1'b0;
            alarm_r <= 1'b0;
            cause_r <= '0;
            fclr_prev_r <= 1'b0;
            nclr_prev_r <= 1'b0;
            dir_flag_r <= `MDIOF_DIR_FLAG_RESET;
            reached_r <= 1'b0;
        end else begin
            drive_r <= drive_nxt;
            fwd_r <= fwd_nxt;
            data_r <= data_nxt;
            tcap_r <= tcap_nxt;
            unlock_r <= unlock_nxt;
            free_r <= free_nxt;
            alarm_r <= alarm_nxt;
            cause_r <= cause_nxt;
            fclr_prev_r <= fault_clear;
            nclr_prev_r <= notice_clear;
            dir_flag_r <= dir_flag_nxt;
            reached_r <= reached_nxt;
        end
    end

    // Rotation pulse generator; one pulse falling due mid-pulse is kept
    logic [SW-1:0] step_cnt_r;
    logic [SW-1:0] step_cnt_nxt;
    logic [PW-1:0] width_r;
    logic [PW-1:0] width_nxt;
    logic pulse_r;
    logic pulse_nxt;
    logic pend_r;
    logic pend_nxt;

    always_comb begin
        step_cnt_nxt = step_cnt_r;
        pend_nxt = pend_r;
        pulse_nxt = pulse_r;
        width_nxt = width_r;
        // one pulse per thirtieth of a revolution
        if (motor_step) begin
            if (step_cnt_r == SW'(STEPS_PER_PULSE - 1)) begin
                step_cnt_nxt = '0;
            end else begin
                step_cnt_nxt = step_cnt_r + 1'b1;
            end
        end
        if (pulse_r) begin
            if (width_r == PW'(PULSE_CYCLES - 1)) begin
                pulse_nxt = 1'b0;
                width_nxt = '0;
            end else begin
                width_nxt = width_r + 1'b1;
            end
        end else if (pend_r) begin
            pulse_nxt = 1'b1;
            pend_nxt = 1'b0;
        end
        if (motor_step && step_cnt_r == SW'(STEPS_PER_PULSE - 1)) begin
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            step_cnt_r <= '0;
            width_r <= '0;
            pulse_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            step_cnt_r <= step_cnt_nxt;
            width_r <= width_nxt;
            pulse_r <= pulse_nxt;
            pend_r <= pend_nxt;
        end
    end

    // Output function vector; unused codes read OFF
    logic [`MDIOF_N_OUT_FUNC-1:0] fvec;
    logic [NO-1:0] dout_r;
    logic [NO-1:0] dout_nxt;
    logic notice_r;
    always_comb begin
        fvec = '0;
        fvec[OF_SPEED_PULSE] = pulse_r;
        fvec[OF_FAULT_NC] = ~alarm_r;
        fvec[OF_FAULT_NO] = alarm_r;
        fvec[OF_TORQUE_CAPPED] = torque_limited & tcap_r;
        fvec[OF_DIRECTION] = dir_flag_r;
        fvec[OF_ROTATING] = motor_turning;
        fvec[OF_NOTICE] = |cause_r;
        fvec[OF_SPEED_REACHED] = reached_r;
        fvec[OF_CAUSE0 +: NC] = cause_r;
        for (int k = 0; k < NO; k++) begin
            dout_nxt[k] = fvec[out_map_r[k*OW +: OW]];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dout_r <= '0;
            notice_r <= 1'b0;
        end else begin
            dout_r <= dout_nxt;
            notice_r <= fvec[OF_NOTICE];
        end
    end

    assign dout = dout_r;
    assign drive_cmd = drive_r;
    assign drive_forward = fwd_r;
    assign data_number = data_r;
    assign torque_cap_active = tcap_r;
    assign tool_unlocked = unlock_r;
    assign shaft_free = free_r;
    assign alarm_active = alarm_r;
    assign notice_flag = notice_r;

endmodule : mdiof_top

// File: mdiof_top_asserts.sv
// Concurrent checks on the ports of the discrete I/O function block
`timescale 1ns/10ps
`include "mdiof_defs.svh"
module mdiof_chk #(
    parameter int unsigned FILT_CYCLES = 4,
    parameter int unsigned PULSE_CYCLES = 5
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`MDIOF_N_IN-1:0] din,
    input wire logic [`MDIOF_N_OUT-1:0] dout,
    input wire logic map_load,
    input wire logic torque_limited,
    input wire logic torque_cap_active,
    input wire logic motor_turning,
    input wire logic motor_reverse,
    input wire logic alarm_raise,
    input wire logic alarm_locked,
    input wire logic alarm_active,
    input wire logic [`MDIOF_N_CAUSE-1:0] notice_cause_set,
    input wire logic notice_flag,
    input wire logic [`MDIOF_DATA_W-1:0] data_number,
    input wire logic drive_forward
);
    logic dflt_r;
    logic [5:0] din_r;
    logic [15:0] quiet_r;
    logic [15:0] high_r;
    // Pin checks hold only while the factory output map is in force
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dflt_r <= 1'b1;
            din_r <= 6'h00;
            quiet_r <= 16'h0000;
            high_r <= 16'h0000;
        end else begin
            dflt_r <= dflt_r && !map_load;
            din_r <= din;
            if (din != din_r || map_load)
                quiet_r <= 16'h0000;
            else if (quiet_r != 16'hFFFF)
                quiet_r <= quiet_r + 16'h0001;
            high_r <= dout[0] ? high_r + 16'h0001 : 16'h0000;
        end
    end

    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // Three stable cycles cover the internal register and the pin register
    property p_fault_pin;
        (dflt_r && $stable(alarm_active)) [*3] |-> dout[1] == !alarm_active;
    endproperty
    a_fault_pin: assert property (p_fault_pin)
        else $error("fault pin disagrees with alarm state");
    property p_tcap_pin;
        (dflt_r && torque_cap_active && $stable(torque_limited)) [*3]
            |-> dout[2] == torque_limited;
    endproperty
    a_tcap_pin: assert property (p_tcap_pin)
        else $error("torque capped pin wrong");
    property p_dir_pin;
        (dflt_r && motor_turning && $stable(motor_reverse)) [*3]
            |-> dout[3] == !motor_reverse;
    endproperty
    a_dir_pin: assert property (p_dir_pin)
        else $error("direction pin wrong while turning");
    property p_pulse_width;
        dflt_r && $fell(dout[0]) |-> high_r == PULSE_CYCLES;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("rotation pulse width wrong");
    property p_alarm_set;
        alarm_raise |-> ##[1:2] alarm_active;
    endproperty
    a_alarm_set: assert property (p_alarm_set)
        else $error("alarm not raised");
    property p_alarm_lock;
        alarm_active && alarm_locked |=> alarm_active;
    endproperty
    a_alarm_lock: assert property (p_alarm_lock)
        else $error("locked alarm was cleared");
    property p_notice_set;
        |notice_cause_set |-> ##[1:3] notice_flag;
    endproperty
    a_notice_set: assert property (p_notice_set)
        else $error("notice flag missing after cause");
    // A quiet input set may not move the data number
    property p_input_quiet;
        quiet_r >= FILT_CYCLES + 8 |-> $stable(data_number);
    endproperty
    a_input_quiet: assert property (p_input_quiet)
        else $error("data number moved with quiet inputs");
    property p_reset_vals;
        $rose(nrst) |-> drive_forward && data_number == 3'h0 && !alarm_active;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong values after reset");

    c_pulse: cover property (dflt_r && $fell(dout[0]));
    c_lock: cover property (alarm_active && alarm_locked);
    c_quiet: cover property (quiet_r == FILT_CYCLES + 8);
endmodule : mdiof_chk

bind mdiof_top mdiof_chk #(
    .FILT_CYCLES(FILT_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)
) u_chk (
    .clock(clock), .nrst(nrst), .din(din), .dout(dout),
    .map_load(map_load), .torque_limited(torque_limited),
    .torque_cap_active(torque_cap_active), .motor_turning(motor_turning),
    .motor_reverse(motor_reverse), .alarm_raise(alarm_raise),
    .alarm_locked(alarm_locked), .alarm_active(alarm_active),
    .notice_cause_set(notice_cause_set), .notice_flag(notice_flag),
    .data_number(data_number), .drive_forward(drive_forward)
);

// File: testbench.sv
// Self-checking testbench of the discrete I/O function block
`timescale 1ns/10ps
`include "mdiof_defs.svh"
module testbench;
    import mdiof_pkg::*;
    localparam int unsigned FILT = 4;
    localparam int unsigned STEPS = 4;
    logic clock, nrst, two_wire_mode, map_load, notice_auto_clear;
    logic motor_step, motor_turning, motor_reverse, torque_limited;
    logic alarm_raise, alarm_locked, p_last, hold_enable;
    logic [5:0] want, din;
    logic [3:0] dout;
    logic [23:0] in_map_cfg;
    logic [19:0] out_map_cfg;
    logic [15:0] speed_width, speed_detected, speed_command;
    logic [15:0] notice_cause_set, notice_cause_present;
    mdiof_drive_type drive_cmd;
    logic drive_forward, torque_cap_active, tool_unlocked, shaft_free;
    logic alarm_active, notice_flag;
    logic [2:0] data_number;
    int mismatches, checks_done, pulses;

    mdiof_plc u_plc (.clock(clock), .want(want), .din(din));
    mdiof_top #(.FILT_CYCLES(FILT), .PULSE_CYCLES(5),
        .STEPS_PER_PULSE(STEPS)) dut (
        .clock(clock), .nrst(nrst), .din(din), .dout(dout),
        .two_wire_mode(two_wire_mode), .map_load(map_load),
        .in_map_cfg(in_map_cfg), .out_map_cfg(out_map_cfg),
        .notice_auto_clear(notice_auto_clear), .hold_enable(hold_enable),
        .speed_width(speed_width), .motor_step(motor_step),
        .motor_turning(motor_turning), .motor_reverse(motor_reverse),
        .torque_limited(torque_limited), .speed_detected(speed_detected),
        .speed_command(speed_command), .alarm_raise(alarm_raise),
        .alarm_locked(alarm_locked), .notice_cause_set(notice_cause_set),
        .notice_cause_present(notice_cause_present), .drive_cmd(drive_cmd),
        .drive_forward(drive_forward), .data_number(data_number),
        .torque_cap_active(torque_cap_active), .tool_unlocked(tool_unlocked),
        .shaft_free(shaft_free), .alarm_active(alarm_active),
        .notice_flag(notice_flag));

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    // Terminal level held well past the debounce time before judging
    task put(input logic [5:0] v);
        @(posedge clock);
        want = v;
        cyc(FILT + 8);
    endtask : put
    task raise;
        @(negedge clock);
        alarm_raise = 1'b1;
        cyc(1);
        alarm_raise = 1'b0;
        cyc(4);
    endtask : raise

    task t_three_wire;
        put(6'h07);
        chk("run", DRV_RUN, drive_cmd);
        chk("forward", 1'b1, drive_forward);
        put(6'h03);
        chk("reverse", 1'b0, drive_forward);
        put(6'h02);
        chk("decel", DRV_DECEL_STOP, drive_cmd);
        put(6'h03);
        chk("rerun", DRV_RUN, drive_cmd);
        put(6'h01);
        chk("instant", DRV_INSTANT_STOP, drive_cmd);
        for (int d = 0; d < 4; d++) begin
            put({1'b0, d[1:0], 3'b000});
            chk("data number", 16'(d), data_number);
        end
        put(6'h00);
    endtask : t_three_wire

    task t_alarm;
        raise();
        chk("fault nc set", 1'b0, dout[1]);
        alarm_locked = 1'b1;
        put(6'h20);
        chk("locked", 1'b1, alarm_active);
        alarm_locked = 1'b0;
        cyc(6);
        chk("level held", 1'b1, alarm_active);
        put(6'h03);
        put(6'h23);
        chk("run blocks", 1'b1, alarm_active);
        put(6'h00);
        put(6'h20);
        chk("cleared", 1'b0, alarm_active);
        chk("fault nc idle", 1'b1, dout[1]);
        put(6'h00);
    endtask : t_alarm

    task t_motor;
        pulses = 0;
        motor_turning = 1'b1;
        for (int i = 0; i < 12; i++) begin
            motor_step = 1'b1;
            cyc(1);
            motor_step = 1'b0;
            cyc(7);
        end
        cyc(12);
        chk("pulse count", 16'(12 / STEPS), 16'(pulses));
        motor_reverse = 1'b1;
        cyc(5);
        chk("dir reverse", 1'b0, dout[3]);
        motor_turning = 1'b0;
        motor_reverse = 1'b0;
        cyc(5);
        chk("dir held", 1'b0, dout[3]);
        motor_turning = 1'b1;
        cyc(5);
        chk("dir forward", 1'b1, dout[3]);
        torque_limited = 1'b1;
        cyc(5);
        chk("torque capped", 1'b1, dout[2]);
        chk("cap default on", 1'b1, torque_cap_active);
        torque_limited = 1'b0;
        motor_turning = 1'b0;
        cyc(5);
        chk("torque free", 1'b0, dout[2]);
    endtask : t_motor

    task t_remap;
        in_map_cfg = {IF_DS2, IF_DS1, IF_DS0, IF_STOP_STYLE, IF_REV, IF_FWD};
        out_map_cfg = {OF_SPEED_REACHED, OF_NOTICE, OF_ROTATING, OF_FAULT_NO};
        two_wire_mode = 1'b1;
        map_load = 1'b1;
        cyc(1);
        map_load = 1'b0;
        cyc(4);
        chk("tool default on", 1'b1, tool_unlocked);
        chk("no trip", 1'b0, alarm_active);
        for (int d = 0; d < 8; d++) begin
            put({d[2:0], 3'b000});
            chk("data number", 16'(d), data_number);
        end
        put(6'h01);
        chk("fwd run", DRV_RUN, drive_cmd);
        chk("fwd dir", 1'b1, drive_forward);
        put(6'h00);
        chk("soft stop", DRV_DECEL_STOP, drive_cmd);
        put(6'h02);
        chk("rev run", DRV_RUN, drive_cmd);
        chk("rev dir", 1'b0, drive_forward);
        put(6'h03);
        chk("both run", DRV_DECEL_STOP, drive_cmd);
        put(6'h06);
        put(6'h04);
        chk("hard stop", DRV_INSTANT_STOP, drive_cmd);
        motor_turning = 1'b1;
        speed_detected = 16'h03ED;
        cyc(5);
        chk("rotating pin", 1'b1, dout[1]);
        chk("speed reached", 1'b1, dout[3]);
        speed_detected = 16'h03F3;
        cyc(5);
        chk("speed outside", 1'b0, dout[3]);
        motor_turning = 1'b0;
        notice_cause_set = 16'h0001;
        cyc(1);
        notice_cause_set = 16'h0000;
        cyc(5);
        chk("notice pin", 1'b1, dout[2]);
        notice_auto_clear = 1'b1;
        cyc(5);
        chk("notice cleared", 1'b0, notice_flag);
        raise();
        chk("fault no pin", 1'b1, dout[0]);
    endtask : t_remap

    task t_inputs;
        put(6'h08);
        in_map_cfg = {IF_NONE, IF_HOLD_REL, IF_EXT_TRIP, IF_TOOL_UNLOCK,
            IF_NOTICE_CLR, IF_TORQUE_CAP};
        map_load = 1'b1;
        cyc(1);
        {map_load, notice_auto_clear} = 2'b00;
        notice_cause_set = 16'h0002;
        cyc(1);
        notice_cause_set = 16'h0000;
        cyc(4);
        chk("cap off", 1'b0, torque_cap_active);
        chk("tool locked", 1'b0, tool_unlocked);
        chk("notice held", 1'b1, notice_flag);
        put(6'h0F);
        chk("notice clear", 1'b0, notice_flag);
        put(6'h17);
        chk("trip stop", DRV_INSTANT_STOP, drive_cmd);
        chk("hold off", 1'b0, shaft_free);
        hold_enable = 1'b1;
        cyc(3);
        chk("shaft free", 1'b1, shaft_free);
    endtask : t_inputs

    // Rising edges of the rotation pulse pin
    always @(negedge clock) begin
        p_last <= dout[0];
        if (dout[0] === 1'b1 && p_last === 1'b0)
            pulses++;
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Watchdog well beyond the expected six hundred or so cycles
    initial begin
        #200000;
        mismatches++;
        $display("[ERR] watchdog expected done seen timeout");
        summarize();
    end
    initial begin
        {nrst, two_wire_mode, map_load, notice_auto_clear, motor_step} = 0;
        {motor_turning, motor_reverse, torque_limited, alarm_raise} = 0;
        {alarm_locked, hold_enable, want, in_map_cfg, out_map_cfg} = 0;
        {notice_cause_set, notice_cause_present} = 0;
        speed_width = 16'h000A;
        speed_command = 16'h03E8;
        speed_detected = 16'h0000;
        cyc(5);
        nrst = 1'b1;
        cyc(3);
        chk("factory pins", 4'hA, dout);
        t_three_wire();
        t_alarm();
        t_motor();
        t_remap();
        t_inputs();
        summarize();
    end
endmodule : testbench
